// ==== hw/wfd_regs.sv ====
// wake frame detector: configuration, status, match and password registers
module wfd_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire wfd_pkg::wfd_bus_s bus,
  output logic [wfd_pkg::DATA_W-1:0] rdata,
  input wire wfd_pkg::wfd_rx_s rx,
  output logic wake_out,
  output logic crc_check_en,
  output logic timestamp_event_en
);
  import wfd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // storage
  logic [DATA_W-1:0] cfg_reg;
  logic [DATA_W-1:0] dest_reg [3];
  logic [DATA_W-1:0] pass_reg [3];
  logic [ST_W-1:0] status_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic wake_reg;
  logic [CNT_W-1:0] pulse_cnt_reg;
  logic [CNT_W-1:0] pulse_len;

  logic wr_cfg;
  logic rd_status;
  logic enh;
  logic frame_valid;
  logic frame_good;
  logic pass_bad;
  logic ev_sfd;
  logic ev_crc;
  logic ev_hack;
  logic ev_ucast;
  logic ev_bcast;
  logic ev_pat;
  logic ev_magic;
  logic wake_event;
  logic [ST_W-1:0] ev_vec;
  logic [47:0] dest_match;
  logic [47:0] pass_match;

  assign wr_cfg = bus.wr && (bus.addr == OFF_CFG);
  assign rd_status = bus.rd && (bus.addr == OFF_STATUS);
  assign dest_match = {dest_reg[2], dest_reg[1], dest_reg[0]};
  assign pass_match = {pass_reg[2], pass_reg[1], pass_reg[0]};

  ////////////////////////////////////////////////////////////////////////////////
  // frame classification
  assign enh = cfg_reg[CFG_ENH_BIT];
  assign frame_valid = rx.done && enh;
  assign frame_good = frame_valid && rx.sfd_ok && rx.crc_ok;
  assign pass_bad = cfg_reg[CFG_PWEN_BIT] && (rx.magic_password != pass_match);
  assign ev_sfd = frame_valid && !rx.sfd_ok;
  assign ev_crc = frame_valid && rx.sfd_ok && !rx.crc_ok;
  assign ev_hack = frame_good && rx.magic_found && pass_bad;
  assign ev_ucast = frame_good && (rx.dest_addr == dest_match);
  assign ev_bcast = frame_good && (rx.dest_addr == 48'hffffffffffff);
  assign ev_pat = frame_good && rx.pattern_hit;
  assign ev_magic = frame_good && rx.magic_found && !pass_bad;

  always_comb begin
    ev_vec = '0;
    ev_vec[ST_SFD_BIT] = ev_sfd;
    ev_vec[ST_CRC_BIT] = ev_crc;
    ev_vec[ST_HACK_BIT] = ev_hack;
    ev_vec[ST_UCAST_BIT] = ev_ucast;
    ev_vec[ST_BCAST_BIT] = ev_bcast;
    ev_vec[ST_PAT_BIT] = ev_pat;
    ev_vec[ST_MAGIC_BIT] = ev_magic;
  end

  assign wake_event = (ev_ucast && cfg_reg[CFG_UCAST_BIT])
                   || (ev_bcast && cfg_reg[CFG_BCAST_BIT])
                   || (ev_pat && cfg_reg[CFG_PAT_BIT])
                   || (ev_magic && cfg_reg[CFG_MAGIC_BIT]);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration register, clear bit self-clears after one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= bus.wdata & CFG_WMASK;
    end else begin
      cfg_reg[CFG_CLEAR_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // destination match and password words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dest_reg[0] <= WORD_RESET;
      dest_reg[1] <= WORD_RESET;
      dest_reg[2] <= WORD_RESET;
    end else if (bus.wr) begin
      if (bus.addr == OFF_DEST0) begin
        dest_reg[0] <= bus.wdata;
      end
      if (bus.addr == OFF_DEST1) begin
        dest_reg[1] <= bus.wdata;
      end
      if (bus.addr == OFF_DEST2) begin
        dest_reg[2] <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pass_reg[0] <= WORD_RESET;
      pass_reg[1] <= WORD_RESET;
      pass_reg[2] <= WORD_RESET;
    end else if (bus.wr) begin
      if (bus.addr == OFF_PASS0) begin
        pass_reg[0] <= bus.wdata;
      end
      if (bus.addr == OFF_PASS1) begin
        pass_reg[1] <= bus.wdata;
      end
      if (bus.addr == OFF_PASS2) begin
        pass_reg[2] <= bus.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status flags, a new event wins over the read clear
  for (genvar i = 0; i < ST_W; i++) begin : g_status
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        status_reg[i] <= 1'b0;
      end else if (ev_vec[i]) begin
        status_reg[i] <= 1'b1;
      end else if (rd_status) begin
        status_reg[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        OFF_CFG: rdata_reg <= cfg_reg;
        OFF_STATUS: rdata_reg <= {{(DATA_W-ST_W){1'b0}}, status_reg};
        OFF_DEST0: rdata_reg <= dest_reg[0];
        OFF_DEST1: rdata_reg <= dest_reg[1];
        OFF_DEST2: rdata_reg <= dest_reg[2];
        OFF_PASS0: rdata_reg <= pass_reg[0];
        OFF_PASS1: rdata_reg <= pass_reg[1];
        OFF_PASS2: rdata_reg <= pass_reg[2];
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wake output, level hold or timed pulse
  always_comb begin
    unique case (cfg_reg[CFG_LEN_LSB +: 2])
      2'b00: pulse_len = PULSE_CYC_00;
      2'b01: pulse_len = PULSE_CYC_01;
      2'b10: pulse_len = PULSE_CYC_10;
      2'b11: pulse_len = PULSE_CYC_11;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end else if (cfg_reg[CFG_LEVEL_BIT]) begin
      pulse_cnt_reg <= '0;
      if (wake_event) begin
        wake_reg <= 1'b1;
      end else if (cfg_reg[CFG_CLEAR_BIT]) begin
        wake_reg <= 1'b0;
      end
    end else if (wake_event) begin
      wake_reg <= 1'b1;
      pulse_cnt_reg <= pulse_len - 4'h1;
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
    end else begin
      wake_reg <= 1'b0;
    end
  end

  assign rdata = rdata_reg;
  assign wake_out = wake_reg;
  assign crc_check_en = cfg_reg[CFG_ENH_BIT];
  assign timestamp_event_en = cfg_reg[CFG_ENH_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_cfg_reset_value: assert property (@(posedge clk)
    $past(!rst_n) && rst_n |-> cfg_reg == CFG_RESET && pass_reg[0] == WORD_RESET)
    else $error("config or password word wrong after reset");

  a_clear_bit_self: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_reg[CFG_CLEAR_BIT] && !wr_cfg |=> !cfg_reg[CFG_CLEAR_BIT])
    else $error("wake clear bit did not self-clear");

  a_level_clear_drop: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_reg[CFG_LEVEL_BIT] && cfg_reg[CFG_CLEAR_BIT] && !wake_event |=> !wake_reg)
    else $error("level wake not cleared");

  a_level_hold_wake: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_reg[CFG_LEVEL_BIT] && wake_reg && !cfg_reg[CFG_CLEAR_BIT] |=> wake_reg)
    else $error("level wake dropped without clear");

  a_pulse_short_len: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_reg[CFG_LEVEL_BIT] && !wake_reg && wake_event
    && cfg_reg[CFG_LEN_LSB +: 2] == 2'b00 && !wr_cfg
    ##1 (!wake_event && !wr_cfg) [*2] |-> $past(wake_reg) && wake_reg ##1 !wake_reg)
    else $error("shortest wake pulse has wrong width");

  a_pulse_long_len: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_reg[CFG_LEVEL_BIT] && !wake_reg && wake_event
    && cfg_reg[CFG_LEN_LSB +: 2] == 2'b11 |=> pulse_cnt_reg == 4'hc && wake_reg)
    else $error("longest wake pulse not loaded");

  a_enh_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !enh && status_reg == '0 && !wake_reg && cfg_reg[CFG_LEVEL_BIT] |=> status_reg == '0 && !wake_reg)
    else $error("detection active with enhanced receive off");

  a_hack_flagged: assert property (@(posedge clk) disable iff (!rst_n)
    frame_good && rx.magic_found && cfg_reg[CFG_PWEN_BIT] && rx.magic_password != pass_match
    |=> status_reg[ST_HACK_BIT])
    else $error("wrong password not flagged");

  a_hack_no_wake: assert property (@(posedge clk) disable iff (!rst_n)
    frame_good && rx.magic_found && cfg_reg[CFG_PWEN_BIT] && rx.magic_password != pass_match
    && !rx.pattern_hit && rx.dest_addr != dest_match && rx.dest_addr != '1 && !wake_reg
    |=> !wake_reg)
    else $error("wrong password raised wake");

  a_magic_no_pass: assert property (@(posedge clk) disable iff (!rst_n)
    frame_good && rx.magic_found && !cfg_reg[CFG_PWEN_BIT] |=> status_reg[ST_MAGIC_BIT])
    else $error("magic frame not accepted without password");

  a_sfd_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status && status_reg[ST_SFD_BIT] && !ev_sfd
    |=> rdata_reg[ST_SFD_BIT] && !status_reg[ST_SFD_BIT])
    else $error("delimiter flag not returned and cleared");

  a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status && ev_crc |=> status_reg[ST_CRC_BIT])
    else $error("crc event lost under read clear");

  a_event_flag_only: assert property (@(posedge clk) disable iff (!rst_n)
    ev_ucast && !cfg_reg[CFG_UCAST_BIT] |=> status_reg[ST_UCAST_BIT])
    else $error("unicast flag needs no wake enable");

  a_read_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == OFF_DEST2 ##1 bus.rd && bus.addr == OFF_DEST2 && !bus.wr
    |=> rdata_reg == $past(bus.wdata, 2) ##1 (rdata_reg == '0 || $past(bus.rd)))
    else $error("destination word read back wrong");

  a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !bus.rd |=> rdata_reg == '0)
    else $error("read data not zero outside read cycle");

  a_cfg_write_mask: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cfg |=> cfg_reg == ($past(bus.wdata) & CFG_WMASK))
    else $error("config write not masked");

  a_cfg_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    bus.rd && bus.addr == OFF_CFG |=> rdata_reg == $past(cfg_reg))
    else $error("config read back wrong");

  a_status_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status
    |=> rdata_reg[ST_W-1:0] == $past(status_reg) && rdata_reg[DATA_W-1:ST_W] == '0)
    else $error("status read back wrong");

  a_status_clear_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status && ev_vec == '0 |=> status_reg == '0)
    else $error("status not cleared by read");

  a_dest0_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == OFF_DEST0 |=> dest_reg[0] == $past(bus.wdata))
    else $error("destination low word not written");

  a_dest1_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == OFF_DEST1 |=> dest_reg[1] == $past(bus.wdata))
    else $error("destination middle word not written");

  a_pass0_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == OFF_PASS0 |=> pass_reg[0] == $past(bus.wdata))
    else $error("password low word not written");

  a_pass2_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.addr == OFF_PASS2 |=> pass_reg[2] == $past(bus.wdata))
    else $error("password high word not written");

  a_ucast_wake: assert property (@(posedge clk) disable iff (!rst_n)
    ev_ucast && cfg_reg[CFG_UCAST_BIT] |=> wake_reg)
    else $error("enabled unicast did not wake");

  a_bcast_wake: assert property (@(posedge clk) disable iff (!rst_n)
    ev_bcast && cfg_reg[CFG_BCAST_BIT] |=> wake_reg)
    else $error("enabled broadcast did not wake");

  a_pattern_wake: assert property (@(posedge clk) disable iff (!rst_n)
    ev_pat && cfg_reg[CFG_PAT_BIT] |=> wake_reg)
    else $error("enabled pattern did not wake");

  a_magic_wake: assert property (@(posedge clk) disable iff (!rst_n)
    ev_magic && cfg_reg[CFG_MAGIC_BIT] |=> wake_reg)
    else $error("enabled magic frame did not wake");

  a_sfd_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rx.done && enh && !rx.sfd_ok |=> status_reg[ST_SFD_BIT])
    else $error("delimiter error not flagged");

  a_crc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rx.done && enh && rx.sfd_ok && !rx.crc_ok |=> status_reg[ST_CRC_BIT])
    else $error("bad crc not flagged");

  a_ucast_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rx.done && enh && rx.sfd_ok && rx.crc_ok && rx.dest_addr == dest_match
    |=> status_reg[ST_UCAST_BIT])
    else $error("unicast frame not flagged");

  a_bcast_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rx.done && enh && rx.sfd_ok && rx.crc_ok && rx.dest_addr == 48'hffffffffffff
    |=> status_reg[ST_BCAST_BIT])
    else $error("broadcast frame not flagged");

  a_pattern_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rx.done && enh && rx.sfd_ok && rx.crc_ok && rx.pattern_hit |=> status_reg[ST_PAT_BIT])
    else $error("pattern frame not flagged");

  a_magic_pass_ok: assert property (@(posedge clk) disable iff (!rst_n)
    rx.done && enh && rx.sfd_ok && rx.crc_ok && rx.magic_found
    && rx.magic_password == pass_match |=> status_reg[ST_MAGIC_BIT])
    else $error("magic frame with right password not flagged");

  a_pulse_mid_len: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_reg[CFG_LEVEL_BIT] && wake_event && cfg_reg[CFG_LEN_LSB +: 2] == 2'b01
    |=> wake_reg && pulse_cnt_reg == PULSE_CYC_01 - 4'h1)
    else $error("second wake pulse length not loaded");

  a_pulse_third_len: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_reg[CFG_LEVEL_BIT] && wake_event && cfg_reg[CFG_LEN_LSB +: 2] == 2'b10
    |=> wake_reg && pulse_cnt_reg == PULSE_CYC_10 - 4'h1)
    else $error("third wake pulse length not loaded");

  a_pulse_count_down: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_reg[CFG_LEVEL_BIT] && !wake_event && pulse_cnt_reg != '0
    |=> wake_reg && pulse_cnt_reg == $past(pulse_cnt_reg) - 4'h1)
    else $error("wake pulse count did not step down");

  a_pulse_end_low: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_reg[CFG_LEVEL_BIT] && !wake_event && pulse_cnt_reg == '0 |=> !wake_reg)
    else $error("wake pulse did not end");

  a_enh_off_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
    !enh |=> (status_reg & ~$past(status_reg)) == '0)
    else $error("flag set with enhanced receive off");

endmodule : wfd_regs

// ==== hw/wfd_pkg.sv ====
// shared constants and carriers of the wake frame detector register bank
package wfd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets, 16-bit registers at their printed addresses
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CFG = 16'h0134;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 16'h0135;
  localparam logic [ADDR_W-1:0] OFF_DEST0 = 16'h0136;
  localparam logic [ADDR_W-1:0] OFF_DEST1 = 16'h0137;
  localparam logic [ADDR_W-1:0] OFF_DEST2 = 16'h0138;
  localparam logic [ADDR_W-1:0] OFF_PASS0 = 16'h0139;
  localparam logic [ADDR_W-1:0] OFF_PASS1 = 16'h013a;
  localparam logic [ADDR_W-1:0] OFF_PASS2 = 16'h013b;

  ////////////////////////////////////////////////////////////////////////////////
  // wake_receive_config fields
  localparam int CFG_CLEAR_BIT = 11;
  localparam int CFG_LEN_LSB = 9;
  localparam int CFG_LEVEL_BIT = 8;
  localparam int CFG_ENH_BIT = 7;
  localparam int CFG_PWEN_BIT = 5;
  localparam int CFG_UCAST_BIT = 4;
  localparam int CFG_BCAST_BIT = 2;
  localparam int CFG_PAT_BIT = 1;
  localparam int CFG_MAGIC_BIT = 0;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0004;
  localparam logic [DATA_W-1:0] CFG_WMASK = 16'h0fb7;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // wake_receive_status fields
  localparam int ST_SFD_BIT = 7;
  localparam int ST_CRC_BIT = 6;
  localparam int ST_HACK_BIT = 5;
  localparam int ST_UCAST_BIT = 4;
  localparam int ST_BCAST_BIT = 2;
  localparam int ST_PAT_BIT = 1;
  localparam int ST_MAGIC_BIT = 0;
  localparam int ST_W = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // wake pulse lengths, given in reference clock cycles, converted rounding up
  localparam longint REF_CLK_HZ = 125000000;
  localparam longint CLK_HZ = 25000000;
  localparam longint PULSE_REF_00 = 8;
  localparam longint PULSE_REF_01 = 16;
  localparam longint PULSE_REF_10 = 32;
  localparam longint PULSE_REF_11 = 64;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] PULSE_CYC_00 = CNT_W'((PULSE_REF_00 * CLK_HZ + REF_CLK_HZ - 1) / REF_CLK_HZ);
  localparam logic [CNT_W-1:0] PULSE_CYC_01 = CNT_W'((PULSE_REF_01 * CLK_HZ + REF_CLK_HZ - 1) / REF_CLK_HZ);
  localparam logic [CNT_W-1:0] PULSE_CYC_10 = CNT_W'((PULSE_REF_10 * CLK_HZ + REF_CLK_HZ - 1) / REF_CLK_HZ);
  localparam logic [CNT_W-1:0] PULSE_CYC_11 = CNT_W'((PULSE_REF_11 * CLK_HZ + REF_CLK_HZ - 1) / REF_CLK_HZ);

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wfd_bus_s;

  typedef struct packed {
    logic done;
    logic sfd_ok;
    logic crc_ok;
    logic pattern_hit;
    logic magic_found;
    logic [47:0] dest_addr;
    logic [47:0] magic_password;
  } wfd_rx_s;

endpackage : wfd_pkg

// ==== test/wfd_frame_src.sv ====
// link partner model: hands one finished frame result to the receive side per request
module wfd_frame_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire wfd_pkg::wfd_rx_s req,
  output wfd_pkg::wfd_rx_s rx
);
  timeunit 1ns;
  timeprecision 1ps;
  import wfd_pkg::*;
  wfd_rx_s last_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // fields outside a frame show the inverse of the last frame, never stale data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_reg <= '0;
    end else if (go) begin
      last_reg <= req;
    end
  end
  always_comb begin
    rx = go ? req : ~last_reg;
    rx.done = go;
  end
endmodule : wfd_frame_src

// ==== test/wfd_regs_tb.sv ====
// testbench of the wake frame detector register bank
module wfd_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wfd_pkg::*;
  logic clk;
  logic rst_n;
  logic go;
  logic rd_pend;
  wfd_bus_s bus;
  wfd_rx_s req;
  wfd_rx_s rx;
  logic [DATA_W-1:0] rdata;
  logic wake_out;
  logic crc_check_en;
  logic timestamp_event_en;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] w[6];
  logic [47:0] dmatch;
  logic [47:0] pw;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int cnt;
  // cfg byte, status, wake, then sfd crc pattern magic, dest kind, wrong password
  localparam logic [31:0] ROWS [11] = '{32'hb780_0044, 32'hb740_0084, 32'hb710_01c0,
    32'hb704_01c4, 32'hb702_01e8, 32'hb701_01d8, 32'hb720_00d9, 32'h8004_00c4,
    32'h8101_01d9, 32'h0000_00c4, 32'h8010_00c0};
  localparam logic [ADDR_W-1:0] OFFS [9] = '{OFF_CFG, OFF_STATUS, OFF_DEST0, OFF_DEST1,
    OFF_DEST2, OFF_PASS0, OFF_PASS1, OFF_PASS2, 16'h0133};
  localparam logic [CNT_W-1:0] PEXP [4] = '{PULSE_CYC_00, PULSE_CYC_01, PULSE_CYC_10,
    PULSE_CYC_11};
  wfd_regs dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .rx(rx),
    .wake_out(wake_out), .crc_check_en(crc_check_en),
    .timestamp_event_en(timestamp_event_en));
  wfd_frame_src src_u (.clk(clk), .rst_n(rst_n), .go(go), .req(req), .rx(rx));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask : rd
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    exp_q.push_back(d);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask : wr_rd
  task automatic frame(input logic [7:0] f);
    @(posedge clk);
    go <= 1'b1;
    req.done <= 1'b1;
    req.sfd_ok <= f[7];
    req.crc_ok <= f[6];
    req.pattern_hit <= f[5];
    req.magic_found <= f[4];
    req.dest_addr <= (f[3:2] == 2'd0) ? dmatch : (f[3:2] == 2'd1) ? '1 : dmatch ^ 48'h1;
    req.magic_password <= f[0] ? ~pw : pw;
    @(posedge clk);
    go <= 1'b0;
  endtask : frame
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  // read data monitor and timeout
  always @(posedge clk) begin
    rd_pend <= bus.rd;
    if (rd_pend === 1'b1 && exp_q.size() > 0) begin
      check("rdata", rdata, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    bus = '0;
    req = '0;
    go = 1'b0;
    rst_n = 1'b0;
    void'($urandom(24408));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(OFFS[i], (i == 0) ? CFG_RESET : WORD_RESET);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      w[i] = 16'($urandom);
      if (i == 2) w[i][15] = 1'b0;
      wr(ADDR_W'(OFF_DEST0 + i), w[i]);
    end
    wr_rd(OFF_DEST2, w[2]);
    for (int i = 0; i < 6; i++) rd(ADDR_W'(OFF_DEST0 + i), w[i]);
    dmatch = {w[2], w[1], w[0]};
    pw = {w[5], w[4], w[3]};
    wr(OFF_CFG, 16'hf7ff);
    rd(OFF_CFG, 16'h07b7);
    wr(OFF_STATUS, 16'hffff);
    wr(16'h0133, 16'hffff);
    rd(OFF_STATUS, 16'h0000);
    rd(16'h0133, 16'h0000);
    $display("test register access done");
    for (int i = 0; i < 11; i++) begin
      wr(OFF_CFG, {8'h00, ROWS[i][31:24]});
      frame(ROWS[i][7:0]);
      #1;
      check("wake_out", {15'h0, wake_out}, {15'h0, ROWS[i][8]});
      check("crc_check_en", {15'h0, crc_check_en}, {15'h0, ROWS[i][31]});
      check("timestamp_en", {15'h0, timestamp_event_en}, {15'h0, ROWS[i][31]});
      rd(OFF_STATUS, {8'h00, ROWS[i][23:16]});
      rd(OFF_STATUS, 16'h0000);
    end
    wr(OFF_CFG, 16'h0080);
    fork
      frame(8'h84);
      rd(OFF_STATUS, 16'h0000);
    join
    rd(OFF_STATUS, 16'h0040);
    $display("test frame classes done");
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CFG, 16'(16'h0084 | (s << 9)));
      frame(8'hc4);
      cnt = 0;
      repeat (20) begin
        #1;
        if (wake_out === 1'b1) cnt++;
        @(posedge clk);
      end
      check("pulse_len", 16'(cnt), {12'h000, PEXP[s]});
    end
    $display("test pulse length done");
    wr(OFF_CFG, 16'h0184);
    frame(8'hc4);
    repeat (20) @(posedge clk);
    #1;
    check("wake_level", {15'h0, wake_out}, 16'h0001);
    wr(OFF_CFG, 16'h0984);
    @(posedge clk);
    #1;
    check("wake_cleared", {15'h0, wake_out}, 16'h0000);
    rd(OFF_CFG, 16'h0184);
    rd(OFF_STATUS, 16'h0004);
    $display("test level clear done");
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule : wfd_regs_tb
